// *** rtl/rps_params.svh ***
// Constants of the rail power sequencer: offsets, masks, reset values, timing
// Function
// RQ1 - Power-down turns rails off by the grouped scheme, not in reverse power-up order
// RQ2 - Power-good is never driven by a power-up slot
// RQ3 - Power-down groups run in descending order, group 4 first, group 1 last
// RQ4 - Buck rail 1 is in power-down group 1
// RQ5 - Buck rails 2, 3, 4, 7 and linear rail 2 are in group 4
// RQ6 - Buck rails 5 and 6 are in group 3, second step
// RQ7 - Linear rail 1 is in group 2, third step
// RQ8 - Linear rails 3 and 4 are in group 1 though never enabled
// RQ9 - Power-good drops with group 4 at the start of shutdown
// RQ10 - Host reset asserts with group 4; its rails follow 10 us later
// RQ11 - Each group is followed by a 120 us delay, same for all groups
// RQ12 - Power-up steps 500 us slots: 1, 40, 60, reset release at 80
// RQ13 - After group 1 completes, hold off 5.0 ms before a new power-up
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

// Clock
`define RPS_CLK_MHZ 250

// Times in their own units and derived cycle counts
`define RPS_SLOT_BASE_US 500
`define RPS_SLOT_BASE_CYC (`RPS_SLOT_BASE_US * `RPS_CLK_MHZ)
`define RPS_RST_GROUP_DLY_US 10
`define RPS_RST_GROUP_DLY_CYC (`RPS_RST_GROUP_DLY_US * `RPS_CLK_MHZ)
`define RPS_GROUP_DLY_US 120
`define RPS_GROUP_DLY_CYC (`RPS_GROUP_DLY_US * `RPS_CLK_MHZ)
`define RPS_PD_HOLD_MS 5.0
`define RPS_PD_HOLD_CYC (int'(`RPS_PD_HOLD_MS * 1000.0 * `RPS_CLK_MHZ))

// Power-up slots
`define RPS_SLOT_FIRST 7'h01
`define RPS_SLOT_LINEAR_1 7'h28
`define RPS_SLOT_BUCK_5_6 7'h3c
`define RPS_SLOT_RESET_REL 7'h50

// Enable masks per slot (buck bit n is rail n+1, linear bit n is rail n+1)
`define RPS_UP_FIRST_BUCK 7'h4f
`define RPS_UP_FIRST_LIN 4'h2
`define RPS_UP_SLOT40_LIN 4'h1
`define RPS_UP_SLOT60_BUCK 7'h30

// Power-down group membership
`define RPS_PD_G4_BUCK 7'h4e
`define RPS_PD_G4_LIN 4'h2
`define RPS_PD_G3_BUCK 7'h30
`define RPS_PD_G3_LIN 4'h0
`define RPS_PD_G2_BUCK 7'h00
`define RPS_PD_G2_LIN 4'h1
`define RPS_PD_G1_BUCK 7'h01
`define RPS_PD_G1_LIN 4'hc
`define RPS_GROUP_TOP 3'h4

// Register offsets (byte addresses)
`define RPS_CTRL_OFS 8'h00
`define RPS_STAT_OFS 8'h04
`define RPS_EVT_OFS 8'h08

// Field positions
`define RPS_CTRL_ON_BIT 0
`define RPS_EVT_DONE_BIT 0

// Reset values
`define RPS_RST_BUCK 7'h00
`define RPS_RST_LIN 4'h0
`define RPS_RST_HOST_RST_N 1'b0
`define RPS_RST_SW_ON 1'b0

`endif

// *** rtl/rps_pkg.sv ***
// Types of the rail power sequencer
package rps_pkg;

	typedef enum logic [2:0] {
		RPS_OFF,
		RPS_UP,
		RPS_ON,
		RPS_DOWN,
		RPS_HOLD
	} rps_phase_t;

	typedef struct packed {
		rps_phase_t phase;
		logic on_meta;
		logic on_sync;
		logic reg_meta;
		logic reg_sync;
		logic sw_on;
		logic done_flag;
		logic [20:0] timer;
		logic [6:0] slot;
		logic [2:0] group;
		logic [6:0] buck;
		logic [3:0] lin;
		logic host_rst_n;
		logic pg_allow;
		logic pg_out;
		logic ack;
		logic [31:0] rdata;
	} rps_state_t;

endpackage

// *** rtl/rps_sequencer.sv ***
// Rail power sequencer with classic Wishbone register slave
`timescale 1ns/100ps
`include "rps_params.svh"

module rps_sequencer import rps_pkg::*; #(
	parameter int SLOT_CYC = `RPS_SLOT_BASE_CYC,
	parameter int GROUP_CYC = `RPS_GROUP_DLY_CYC,
	parameter int HOLD_CYC = `RPS_PD_HOLD_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins from outside
	input wire logic power_on_in,
	input wire logic rails_in_regulation,
	// Rail enables and host signals
	output logic [6:0] buck_rail_en,
	output logic [3:0] linear_rail_en,
	output logic host_reset_out_n,
	output logic power_good_out
);

	localparam logic [20:0] SLOT_LOAD = 21'(SLOT_CYC - 1);
	localparam logic [20:0] GROUP_LOAD = 21'(GROUP_CYC - 1);
	localparam logic [20:0] HOLD_LOAD = 21'(HOLD_CYC - 1);
	localparam logic [20:0] RST_LOAD = 21'(`RPS_RST_GROUP_DLY_CYC - 1);

	rps_state_t s_q;
	rps_state_t s_d;

	logic on_req;
	logic tick;
	logic bus_req;
	logic bus_wr;
	logic [31:0] stat_word;

	assign on_req = s_q.on_sync | s_q.sw_on;
	assign tick = (s_q.timer == 21'h0);
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_req & wb_we_i & ~s_q.ack;

	assign stat_word = {2'h0, 3'(s_q.phase), 1'b0, s_q.group, 1'b0, s_q.slot, 1'b0,
		s_q.lin, 1'b0, s_q.buck, s_q.host_rst_n, s_q.pg_out};

	always_comb begin
		s_d = s_q;

		// Two-stage synchronisers for the pins
		s_d.on_meta = power_on_in;
		s_d.on_sync = s_q.on_meta;
		s_d.reg_meta = rails_in_regulation;
		s_d.reg_sync = s_q.reg_meta;

		if (!tick) begin
			s_d.timer = s_q.timer - 21'h1;
		end

		case (s_q.phase)
			RPS_OFF: begin
				if (on_req) begin
					s_d.phase = RPS_UP;
					s_d.slot = 7'h00;
					s_d.timer = SLOT_LOAD;
					s_d.pg_allow = 1'b1;
				end
			end
			RPS_UP: begin
				if (tick) begin
					s_d.slot = s_q.slot + 7'h1;
					s_d.timer = SLOT_LOAD;
					case (s_q.slot + 7'h1)
						`RPS_SLOT_FIRST: begin
							s_d.buck = s_q.buck | `RPS_UP_FIRST_BUCK; // see RQ12
							s_d.lin = s_q.lin | `RPS_UP_FIRST_LIN; // see RQ12
						end
						`RPS_SLOT_LINEAR_1: begin
							s_d.lin = s_q.lin | `RPS_UP_SLOT40_LIN; // see RQ12
						end
						`RPS_SLOT_BUCK_5_6: begin
							s_d.buck = s_q.buck | `RPS_UP_SLOT60_BUCK; // see RQ12
						end
						`RPS_SLOT_RESET_REL: begin
							s_d.host_rst_n = 1'b1; // see RQ12
							s_d.phase = RPS_ON;
						end
						default: begin
						end
					endcase
				end
			end
			RPS_ON: begin
			end
			RPS_DOWN: begin
				if (tick) begin
					s_d.timer = GROUP_LOAD; // see RQ11
					s_d.group = s_q.group - 3'h1; // see RQ3
					case (s_q.group)
						3'h4: begin
							s_d.buck = s_q.buck & ~`RPS_PD_G4_BUCK; // see RQ5
							s_d.lin = s_q.lin & ~`RPS_PD_G4_LIN; // see RQ5
						end
						3'h3: begin
							s_d.buck = s_q.buck & ~`RPS_PD_G3_BUCK; // see RQ6
							s_d.lin = s_q.lin & ~`RPS_PD_G3_LIN;
						end
						3'h2: begin
							s_d.buck = s_q.buck & ~`RPS_PD_G2_BUCK;
							s_d.lin = s_q.lin & ~`RPS_PD_G2_LIN; // see RQ7
						end
						3'h1: begin
							s_d.buck = s_q.buck & ~`RPS_PD_G1_BUCK; // see RQ4
							s_d.lin = s_q.lin & ~`RPS_PD_G1_LIN; // see RQ8
						end
						default: begin
							// Group 1 delay elapsed: start the restart hold-off
							s_d.group = 3'h0;
							s_d.phase = RPS_HOLD;
							s_d.timer = HOLD_LOAD; // see RQ13
						end
					endcase
				end
			end
			RPS_HOLD: begin
				if (tick) begin
					s_d.phase = RPS_OFF; // see RQ13
					s_d.done_flag = 1'b1;
				end
			end
			default: begin
				s_d.phase = RPS_OFF;
			end
		endcase

		// Loss of the on request starts the grouped shutdown, which does not mirror power-up
		if ((s_q.phase == RPS_UP || s_q.phase == RPS_ON) && !on_req) begin
			s_d.phase = RPS_DOWN; // see RQ1
			s_d.group = `RPS_GROUP_TOP; // see RQ3
			s_d.host_rst_n = 1'b0; // see RQ10
			s_d.pg_allow = 1'b0; // see RQ9
			s_d.timer = RST_LOAD; // see RQ10
			s_d.buck = s_q.buck;
			s_d.lin = s_q.lin;
			s_d.slot = s_q.slot;
		end

		// Power-good follows regulation, gated off from reset or shutdown until the next power-up starts
		s_d.pg_out = s_q.reg_sync & s_d.pg_allow; // see RQ2

		// Wishbone: one wait state, ack for one cycle, unmapped reads zero
		s_d.ack = bus_req & ~s_q.ack;
		s_d.rdata = 32'h0;
		if (bus_req && !s_q.ack) begin
			case (wb_adr_i)
				`RPS_CTRL_OFS: s_d.rdata = {31'h0, s_q.sw_on};
				`RPS_STAT_OFS: s_d.rdata = stat_word;
				`RPS_EVT_OFS: s_d.rdata = {31'h0, s_q.done_flag};
				default: s_d.rdata = 32'h0;
			endcase
		end
		if (bus_wr && wb_sel_i[0]) begin
			case (wb_adr_i)
				`RPS_CTRL_OFS: s_d.sw_on = wb_dat_i[`RPS_CTRL_ON_BIT];
				`RPS_EVT_OFS: begin
					// Write one clears; a completion in the same cycle wins
					if (wb_dat_i[`RPS_EVT_DONE_BIT] && !(s_q.phase == RPS_HOLD && tick)) begin
						s_d.done_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.phase <= RPS_OFF;
			s_q.buck <= `RPS_RST_BUCK;
			s_q.lin <= `RPS_RST_LIN;
			s_q.host_rst_n <= `RPS_RST_HOST_RST_N;
			s_q.sw_on <= `RPS_RST_SW_ON;
		end else begin
			s_q <= s_d;
		end
	end

	assign buck_rail_en = s_q.buck;
	assign linear_rail_en = s_q.lin;
	assign host_reset_out_n = s_q.host_rst_n;
	assign power_good_out = s_q.pg_out;
	assign wb_dat_o = s_q.rdata;
	assign wb_ack_o = s_q.ack;

endmodule

// *** verif/rps_sequencer_checker.sv ***
// Checker for rail enable order and spacing of the sequencer
`timescale 1ns/100ps
module rps_sequencer_checker #(
	parameter int GROUP_CYC = 10
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Rail and host outputs
	input wire logic [6:0] buck_rail_en,
	input wire logic [3:0] linear_rail_en,
	input wire logic host_reset_out_n,
	input wire logic power_good_out
);
	localparam int G = GROUP_CYC;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_PG_DROP: assert property ($fell(host_reset_out_n) |-> !power_good_out)
		else $error("pg high at host reset");
	AST_G4_LATE: assert property ($fell(buck_rail_en[1]) |-> !$past(host_reset_out_n, 2499))
		else $error("group 4 early");
	AST_G4_SET: assert property ($fell(buck_rail_en[1]) |-> (buck_rail_en & 7'h4e) == 7'h00 && !linear_rail_en[1])
		else $error("group 4 split");
	AST_G3_GAP: assert property ($fell(buck_rail_en[1]) && buck_rail_en[4] |-> ##G $fell(buck_rail_en[4]))
		else $error("group 3 spacing");
	AST_G2_GAP: assert property ($fell(buck_rail_en[4]) && linear_rail_en[0] |-> ##G $fell(linear_rail_en[0]))
		else $error("group 2 spacing");
	AST_G1_GAP: assert property ($fell(linear_rail_en[0]) |-> ##G $fell(buck_rail_en[0]))
		else $error("group 1 spacing");
	AST_LIN_OFF: assert property (linear_rail_en[3:2] == 2'h0)
		else $error("linear 3 or 4 on");
	AST_SLOT60: assert property ($rose(buck_rail_en[4]) |-> buck_rail_en == 7'h7f && !host_reset_out_n)
		else $error("slot 60 set");
	cover property ($fell(buck_rail_en[0]));
	cover property ($rose(host_reset_out_n));
	cover property ($rose(buck_rail_en[4]));
endmodule

// *** verif/rps_rail_model.sv ***
// Regulators: report regulation some cycles after the bucks enable
`timescale 1ns/100ps
module rps_rail_model (
	// Clock and mode
	input wire logic core_clk,
	input wire logic slow,
	// From the sequencer
	input wire logic [6:0] buck_rail_en,
	output logic rails_in_regulation
);
	logic [7:0] ramp_q = 8'h00;
	always_ff @(posedge core_clk) ramp_q <= {ramp_q[6:0], |buck_rail_en};
	assign rails_in_regulation = slow ? ramp_q[7] : ramp_q[0];
endmodule

// *** verif/tb.sv ***
// Testbench: power-up, grouped power-down and registers
`timescale 1ns/100ps
module tb;
	localparam int S = 20;
	logic core_clk = 0, reset_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, pon = 0, slow = 0, reg_ok, ack, hrst_n, pg;
	logic [7:0] adr = 0;
	logic [31:0] dat = 0, rd_o, r;
	logic [6:0] buck;
	logic [3:0] lin;
	int miscompares = 0, compares = 0, cyc = 0, t;
	rps_sequencer #(.SLOT_CYC(S), .GROUP_CYC(10), .HOLD_CYC(30)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.wb_cyc_i(cyc_i), .wb_stb_i(stb_i), .wb_we_i(we_i), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rd_o), .wb_ack_o(ack), .power_on_in(pon), .rails_in_regulation(reg_ok),
		.buck_rail_en(buck), .linear_rail_en(lin), .host_reset_out_n(hrst_n), .power_good_out(pg));
	rps_rail_model far (.core_clk(core_clk), .slow(slow), .buck_rail_en(buck), .rails_in_regulation(reg_ok));
	initial forever #2 core_clk = ~core_clk;
	always @(negedge core_clk) cyc++;
	task automatic chk(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic gap(input string n, input int e);
		#1;
		chk(n, 32'(cyc - t), e);
		t = cyc;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk);
		{cyc_i, stb_i, we_i, adr, dat} <= {2'b11, we, a, d};
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rd_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic t_up;
		@(posedge core_clk);
		pon <= 1;
		#1;
		t = cyc;
		@(posedge buck[0]);
		gap("slot1", S + 3);
		chk("slot1", {buck, lin}, 11'h4f2);
		@(posedge lin[0]);
		gap("slot40", 39 * S);
		chk("pg", {pg, hrst_n}, 2'h2);
		@(posedge buck[4]);
		gap("slot60", 20 * S);
		@(posedge hrst_n);
		gap("slot80", 20 * S);
	endtask
	task automatic t_regs;
		wb(0, 8'h04, 0, r);
		chk("stat", r & 32'h38003fff, 32'h10000dff);
		wb(0, 8'h0c, 0, r);
		chk("unmapped", r, 0);
	endtask
	task automatic t_down;
		pon <= 0;
		#1;
		t = cyc;
		@(negedge hrst_n);
		gap("pg", 3);
		chk("pg", {pg, buck, lin}, 12'h7f3);
		@(negedge buck[1]);
		gap("g4", 2500);
		chk("g4", {buck, lin}, 11'h311);
		@(negedge buck[4]);
		gap("g3", 10);
		chk("g3", {buck, lin}, 11'h011);
		@(negedge lin[0]);
		gap("g2", 10);
		chk("g2", {buck, lin}, 11'h010);
		@(negedge buck[0]);
		gap("g1", 10);
		chk("g1", lin, 0);
		wb(1, 8'h00, 1, r);
		slow <= 1;
		@(posedge buck[0]);
		gap("hold", 10 + 30 + 1 + S);
		wb(0, 8'h08, 0, r);
		chk("done", r, 1);
		wb(1, 8'h08, 1, r);
		wb(0, 8'h08, 0, r);
		chk("clr", r, 0);
	endtask
	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1;
		#1;
		chk("rst", {buck, lin, hrst_n, pg}, 0);
		t_up;
		t_regs;
		t_down;
		finish_test;
	end
endmodule
bind rps_sequencer rps_sequencer_checker #(.GROUP_CYC(GROUP_CYC)) chk_i (.core_clk(core_clk), .reset_n(reset_n),
	.buck_rail_en(buck_rail_en), .linear_rail_en(linear_rail_en), .host_reset_out_n(host_reset_out_n),
	.power_good_out(power_good_out));
